// ### core/tpct_top.sv
// The address map and register access over AXI4-Lite were left to the implementer.
`timescale 1ns/10ps
// =========================================================
// two timer channels behind an axi4-lite register slave
module tpct_top (
  // clock and reset
  input  wire logic        clk_in,
  input  wire logic        sys_rst_in,
  // axi4-lite write address and data
  input  wire logic        axi_awvalid_in,
  output logic             axi_awready_out,
  input  wire logic [7:0]  axi_awaddr_in,
  input  wire logic [2:0]  axi_awprot_in,
  input  wire logic        axi_wvalid_in,
  output logic             axi_wready_out,
  input  wire logic [31:0] axi_wdata_in,
  input  wire logic [3:0]  axi_wstrb_in,
  // axi4-lite write response
  output logic             axi_bvalid_out,
  input  wire logic        axi_bready_in,
  output logic [1:0]       axi_bresp_out,
  // axi4-lite read
  input  wire logic        axi_arvalid_in,
  output logic             axi_arready_out,
  input  wire logic [7:0]  axi_araddr_in,
  input  wire logic [2:0]  axi_arprot_in,
  output logic             axi_rvalid_out,
  input  wire logic        axi_rready_in,
  output logic [31:0]      axi_rdata_out,
  output logic [1:0]       axi_rresp_out,
  // timer pins, one per channel
  input  wire logic [1:0]  trigger_input_pin_in,
  output logic [1:0]       pulse_output_pin_out,
  output logic [1:0]       match_interrupt_out
);

  // =======================================================
  // decoding shared by the read and write paths
  function automatic logic addr_hit(input logic [7:0] a);
    addr_hit = (a[7] == 1'b0) && (a[5:2] <= tpct_pkg::IDX_LAST)
               && (a[1:0] == 2'b00);
  endfunction : addr_hit

  function automatic logic [31:0] merge(input logic [31:0] old,
                                        input logic [31:0] nw,
                                        input logic [3:0]  be);
    logic [31:0] m;
    m = old;
    for (int b = 0; b < 4; b++) begin
      if (be[b]) begin
        m[8*b +: 8] = nw[8*b +: 8];
      end
    end
    merge = m;
  endfunction : merge

  // =======================================================
  // bus handshake state
  logic        awready_r;
  logic        bvalid_r;
  logic [1:0]  bresp_r;
  logic        arready_r;
  logic        rvalid_r;
  logic [31:0] rdata_r;
  logic [1:0]  rresp_r;

  wire         wr_fire = awready_r & axi_awvalid_in & axi_wvalid_in;
  wire         rd_fire = arready_r & axi_arvalid_in;
  wire         wr_hit  = addr_hit(axi_awaddr_in);
  wire         rd_hit  = addr_hit(axi_araddr_in);
  wire         wr_ch   = axi_awaddr_in[tpct_pkg::CH_BIT];
  wire         rd_ch   = axi_araddr_in[tpct_pkg::CH_BIT];
  wire [3:0]   wr_idx  = axi_awaddr_in[5:2];
  wire [3:0]   rd_idx  = axi_araddr_in[5:2];

  // read view of every channel register, indexed by channel
  logic [31:0] view_w [2][11];
  logic [31:0] rd_val;
  logic [31:0] wr_old;
  logic [31:0] wr_val;
  assign rd_val = view_w[rd_ch][rd_idx];
  assign wr_old = view_w[wr_ch][wr_idx];
  assign wr_val = merge(wr_old, axi_wdata_in, axi_wstrb_in);

  // =======================================================
  // write channel: take address and data together, then answer
  always_ff @(posedge clk_in) begin
    if (sys_rst_in) begin
      awready_r <= 1'b0;
      bvalid_r  <= 1'b0;
      bresp_r   <= tpct_pkg::RESP_OKAY;
    end else begin
      awready_r <= axi_awvalid_in & axi_wvalid_in & ~awready_r & ~bvalid_r;
      if (wr_fire) begin
        bvalid_r <= 1'b1;
        bresp_r  <= wr_hit ? tpct_pkg::RESP_OKAY : tpct_pkg::RESP_SLVERR;
      end else if (axi_bready_in) begin
        bvalid_r <= 1'b0;
      end
    end
  end

  // =======================================================
  // read channel: one beat, data registered with the answer
  always_ff @(posedge clk_in) begin
    if (sys_rst_in) begin
      arready_r <= 1'b0;
      rvalid_r  <= 1'b0;
      rdata_r   <= 32'h0000_0000;
      rresp_r   <= tpct_pkg::RESP_OKAY;
    end else begin
      arready_r <= axi_arvalid_in & ~arready_r & ~rvalid_r;
      if (rd_fire) begin
        rvalid_r <= 1'b1;
        rdata_r  <= rd_hit ? rd_val : 32'h0000_0000;
        rresp_r  <= rd_hit ? tpct_pkg::RESP_OKAY : tpct_pkg::RESP_SLVERR;
      end else if (axi_rready_in) begin
        rvalid_r <= 1'b0;
      end
    end
  end

  assign axi_awready_out = awready_r;
  assign axi_wready_out  = awready_r;
  assign axi_bvalid_out  = bvalid_r;
  assign axi_bresp_out   = bresp_r;
  assign axi_arready_out = arready_r;
  assign axi_rvalid_out  = rvalid_r;
  assign axi_rdata_out   = rdata_r;
  assign axi_rresp_out   = rresp_r;

  // =======================================================
  // per channel register file and timer
  tpct_ch_if ch_if [2] ();
  logic [1:0] ff_w;

  genvar g;
  generate
    for (g = 0; g < 2; g++) begin : g_ch
      logic [2:0]  run_r;
      logic [1:0]  ctrl_r;
      logic [5:0]  mode_r;
      logic [1:0]  ffc_r;
      logic [2:0]  mask_r;
      logic [15:0] cmp0_r;
      logic [15:0] cmp1_r;
      logic        ffclr_r;
      logic        ffset_r;
      logic        swcap_r;

      // write strobe per register of this channel
      wire sel     = wr_fire & wr_hit & (wr_ch == 1'(g));
      wire w_run   = sel & (wr_idx == tpct_pkg::IDX_RUN);
      wire w_ctrl  = sel & (wr_idx == tpct_pkg::IDX_CTRL);
      wire w_mode  = sel & (wr_idx == tpct_pkg::IDX_MODE);
      wire w_ffc   = sel & (wr_idx == tpct_pkg::IDX_FFC);
      wire w_mask  = sel & (wr_idx == tpct_pkg::IDX_MASK);
      wire w_cmp0  = sel & (wr_idx == tpct_pkg::IDX_CMP0);
      wire w_cmp1  = sel & (wr_idx == tpct_pkg::IDX_CMP1);

      // stored settings
      always_ff @(posedge clk_in) begin
        if (sys_rst_in) begin
          run_r  <= tpct_pkg::RUN_RST;
          ctrl_r <= tpct_pkg::CTRL_RST;
          mode_r <= tpct_pkg::MODE_RST;
          ffc_r  <= tpct_pkg::FFC_RST;
          mask_r <= tpct_pkg::MASK_RST;
          cmp0_r <= tpct_pkg::CMP_RST;
          cmp1_r <= tpct_pkg::CMP_RST;
        end else begin
          if (w_run)  run_r  <= wr_val[2:0];                  // RULE_13
          if (w_ctrl) ctrl_r <= wr_val[1:0];
          if (w_mode) mode_r <= wr_val[5:0];                  // RULE_10
          if (w_ffc)  ffc_r  <= wr_val[3:2];                  // RULE_09
          if (w_mask) mask_r <= wr_val[2:0];                  // RULE_12
          if (w_cmp0) cmp0_r <= wr_val[15:0];                 // RULE_20
          if (w_cmp1) cmp1_r <= wr_val[15:0];                 // RULE_20
        end
      end

      // one-cycle actions that a write carries
      always_ff @(posedge clk_in) begin
        if (sys_rst_in) begin
          ffclr_r <= 1'b0;
          ffset_r <= 1'b0;
          swcap_r <= 1'b0;
        end else begin
          ffclr_r <= w_ffc & (wr_val[1:0] == tpct_pkg::FFC_CLEAR); // RULE_09
          ffset_r <= w_ffc & (wr_val[1:0] == tpct_pkg::FFC_SET);
          swcap_r <= w_mode & ~wr_val[tpct_pkg::MODE_SWC];    // RULE_19
        end
      end

      // settings to the channel
      assign ch_if[g].prescaler_run        = run_r[tpct_pkg::RUN_PSC];
      assign ch_if[g].counter_run          = run_r[tpct_pkg::RUN_CNT];
      assign ch_if[g].count_start_select   = ctrl_r[tpct_pkg::CTRL_CSS];
      assign ch_if[g].trigger_edge_select  = ctrl_r[tpct_pkg::CTRL_TRG];
      assign ch_if[g].clock_source_select  = mode_r[2:0];
      assign ch_if[g].capture_mode         = mode_r[4:3];
      assign ch_if[g].clear_on_match       = mode_r[tpct_pkg::MODE_CLR];
      assign ch_if[g].toggle_on_match_zero = ffc_r[0];
      assign ch_if[g].toggle_on_match_one  = ffc_r[1];
      assign ch_if[g].interrupt_mask       = mask_r;
      assign ch_if[g].compare_reg_zero     = cmp0_r;
      assign ch_if[g].compare_reg_one      = cmp1_r;
      assign ch_if[g].ff_clear             = ffclr_r;
      assign ch_if[g].ff_set               = ffset_r;
      assign ch_if[g].soft_capture         = swcap_r;

      // read view; action bits read back as their idle value
      assign view_w[g][0]  = {29'h0, run_r};
      assign view_w[g][1]  = {30'h0, ctrl_r};
      assign view_w[g][2]  = {25'h0, 1'b1, mode_r};
      assign view_w[g][3]  = {28'h0, ffc_r, tpct_pkg::FFC_IDLE};
      assign view_w[g][4]  = {29'h0, mask_r};
      assign view_w[g][5]  = {16'h0, cmp0_r};
      assign view_w[g][6]  = {16'h0, cmp1_r};
      assign view_w[g][7]  = {16'h0, ch_if[g].up_counter};
      assign view_w[g][8]  = {16'h0, ch_if[g].capture_reg_zero};
      assign view_w[g][9]  = {16'h0, ch_if[g].capture_reg_one};
      assign view_w[g][10] = {30'h0, ch_if[g].started,
                              ch_if[g].timer_flip_flop};

      assign ff_w[g] = ch_if[g].timer_flip_flop;

      // each channel captures on the other channel's flip-flop
      tpct_chan u_chan (
        .clk_in         (clk_in),
        .sys_rst_in     (sys_rst_in),
        .trigger_pin_in (trigger_input_pin_in[g]),
        .partner_ff_in  (ff_w[1-g]),                          // RULE_14
        .ch             (ch_if[g])
      );

      // pin and interrupt come straight from channel flops
      assign pulse_output_pin_out[g] = ch_if[g].timer_flip_flop; // RULE_22
      assign match_interrupt_out[g]  = ch_if[g].match_interrupt; // RULE_07
    end
  endgenerate

endmodule : tpct_top

// ### core/tpct_pkg.sv
// Notes on behaviour
// RULE_01: software arms trigger start with edge select
// RULE_02: software loads delay and delay plus width
// RULE_03: flip-flop toggles on each enabled compare match
// RULE_04: both run bits arm; trigger edge starts
// RULE_05: delay match raises the output
// RULE_06: delay plus width match lowers output
// RULE_07: compare one match raises match interrupt
// RULE_08: handler stops toggling or stops counter
// RULE_09: control bits enable toggles, 1 0 clears
// RULE_10: mode value selects free run, tap one
// RULE_11: clock select zero counts input pin edges
// RULE_12: mask bits gate overflow and both matches
// RULE_13: run bit two prescaler, bit zero counter
// RULE_14: capture mode 11 latches on partner edges
// RULE_15: partner rise captures zero, fall captures one
// RULE_16: software corrects negative capture difference
// RULE_17: external clock counts rising pin edges
// RULE_18: software keeps compare zero below one
// RULE_19: writing mode bit six low captures count
// RULE_20: compare registers are sixteen bits wide
// RULE_21: counter wraps to zero after maximum
// RULE_22: flip-flop drives pulse output pin always
package tpct_pkg;

  // =======================================================
  // bus and channel layout
  localparam int unsigned NUM_CH     = 2;
  localparam int unsigned ADDR_W     = 8;
  localparam int unsigned CNT_W      = 16;
  localparam int unsigned CH_BIT     = 6;   // address bit picking the channel
  localparam int unsigned PSC_W      = 8;

  // =======================================================
  // register indices (byte address = 4 * index + 64 * channel)
  localparam logic [3:0] IDX_RUN     = 4'h0;
  localparam logic [3:0] IDX_CTRL    = 4'h1;
  localparam logic [3:0] IDX_MODE    = 4'h2;
  localparam logic [3:0] IDX_FFC     = 4'h3;
  localparam logic [3:0] IDX_MASK    = 4'h4;
  localparam logic [3:0] IDX_CMP0    = 4'h5;
  localparam logic [3:0] IDX_CMP1    = 4'h6;
  localparam logic [3:0] IDX_COUNT   = 4'h7;
  localparam logic [3:0] IDX_CAP0    = 4'h8;
  localparam logic [3:0] IDX_CAP1    = 4'h9;
  localparam logic [3:0] IDX_STATUS  = 4'ha;
  localparam logic [3:0] IDX_LAST    = 4'ha;

  // =======================================================
  // field positions
  localparam int unsigned RUN_CNT    = 0;
  localparam int unsigned RUN_PSC    = 2;
  localparam int unsigned CTRL_TRG   = 0;  // trigger edge select
  localparam int unsigned CTRL_CSS   = 1;  // count start select
  localparam int unsigned MODE_CLK   = 0;  // bits 2:0 clock source
  localparam int unsigned MODE_CLR   = 5;  // clear on compare one
  localparam int unsigned MODE_CPM   = 3;  // bits 4:3 capture mode
  localparam int unsigned MODE_SWC   = 6;  // write 0 soft capture
  localparam int unsigned FFC_TGL0   = 2;
  localparam int unsigned FFC_TGL1   = 3;
  localparam int unsigned MASK_CMP0  = 0;
  localparam int unsigned MASK_CMP1  = 1;
  localparam int unsigned MASK_OVF   = 2;

  // =======================================================
  // encodings and values after reset
  localparam logic [1:0] FFC_CLEAR   = 2'h2;
  localparam logic [1:0] FFC_SET     = 2'h1;
  localparam logic [1:0] FFC_IDLE    = 2'h3;
  localparam logic [1:0] CPM_PIN     = 2'h2;
  localparam logic [1:0] CPM_PARTNER = 2'h3;
  localparam logic [2:0] CLK_PIN     = 3'h0;
  localparam logic [2:0] RUN_RST     = 3'h0;
  localparam logic [1:0] CTRL_RST    = 2'h0;
  localparam logic [5:0] MODE_RST    = 6'h00;
  localparam logic [1:0] FFC_RST     = 2'h0;
  localparam logic [2:0] MASK_RST    = 3'h0;
  localparam logic [15:0] CMP_RST    = 16'h0000;
  localparam logic [1:0] RESP_OKAY   = 2'h0;
  localparam logic [1:0] RESP_SLVERR = 2'h2;

endpackage : tpct_pkg

// ### core/tpct_ch_if.sv
`timescale 1ns/10ps
// =========================================================
// settings from the register file and state back from a channel
interface tpct_ch_if;
  logic        prescaler_run;
  logic        counter_run;
  logic        count_start_select;
  logic        trigger_edge_select;
  logic [2:0]  clock_source_select;
  logic [1:0]  capture_mode;
  logic        clear_on_match;
  logic        toggle_on_match_zero;
  logic        toggle_on_match_one;
  logic [2:0]  interrupt_mask;
  logic [15:0] compare_reg_zero;
  logic [15:0] compare_reg_one;
  logic        ff_clear;
  logic        ff_set;
  logic        soft_capture;
  logic [15:0] up_counter;
  logic [15:0] capture_reg_zero;
  logic [15:0] capture_reg_one;
  logic        timer_flip_flop;
  logic        match_interrupt;
  logic        started;

  modport regs (
    output prescaler_run, counter_run, count_start_select,
           trigger_edge_select, clock_source_select, capture_mode,
           clear_on_match, toggle_on_match_zero, toggle_on_match_one,
           interrupt_mask, compare_reg_zero, compare_reg_one,
           ff_clear, ff_set, soft_capture,
    input  up_counter, capture_reg_zero, capture_reg_one,
           timer_flip_flop, match_interrupt, started
  );
  modport chan (
    input  prescaler_run, counter_run, count_start_select,
           trigger_edge_select, clock_source_select, capture_mode,
           clear_on_match, toggle_on_match_zero, toggle_on_match_one,
           interrupt_mask, compare_reg_zero, compare_reg_one,
           ff_clear, ff_set, soft_capture,
    output up_counter, capture_reg_zero, capture_reg_one,
           timer_flip_flop, match_interrupt, started
  );
endinterface : tpct_ch_if

// ### core/tpct_chan.sv
`timescale 1ns/10ps
// =========================================================
// one timer channel: prescaler, up counter, matches, flip-flop
module tpct_chan (
  // clock and reset
  input  wire logic clk_in,
  input  wire logic sys_rst_in,
  // pins and partner channel
  input  wire logic trigger_pin_in,
  input  wire logic partner_ff_in,
  // settings and state
  tpct_ch_if.chan   ch
);

  logic [7:0]  psc_r;
  logic        pin_d_r;
  logic        partner_d_r;
  logic        started_r;
  logic        started_nxt;
  logic [15:0] cnt_r;
  logic [15:0] cnt_nxt;
  logic [15:0] cap0_r;
  logic [15:0] cap1_r;
  logic        ff_r;
  logic        ff_nxt;
  logic        irq_r;

  // =======================================================
  // edges and clock source
  wire       pin_rise  = trigger_pin_in & ~pin_d_r;
  wire       pin_fall  = ~trigger_pin_in & pin_d_r;
  wire       par_rise  = partner_ff_in & ~partner_d_r;
  wire       par_fall  = ~partner_ff_in & partner_d_r;
  wire [7:0] tap_hit;
  assign tap_hit[0] = pin_rise;                       // RULE_11 RULE_17
  genvar k;
  generate
    for (k = 1; k < 8; k++) begin : g_tap
      // tap k ticks once every 2**k clocks
      assign tap_hit[k] = ch.prescaler_run & (&psc_r[k-1:0]);
    end
  endgenerate
  wire tick      = tap_hit[ch.clock_source_select];
  wire trig_edge = ch.trigger_edge_select ? pin_fall : pin_rise;

  // =======================================================
  // start, advance and match decode
  wire running  = ch.counter_run & (~ch.count_start_select | started_r);
  wire adv      = running & tick;
  wire clr_hit  = ch.clear_on_match & (cnt_r == ch.compare_reg_one);
  wire m0       = adv & (cnt_nxt == ch.compare_reg_zero);   // RULE_05
  wire m1       = adv & (cnt_nxt == ch.compare_reg_one);    // RULE_06
  wire ovf      = adv & ~clr_hit & (&cnt_r);

  // armed counter waits for the selected trigger edge
  assign started_nxt = ~ch.counter_run ? 1'b0 :               // RULE_04
                       (ch.count_start_select & trig_edge) ? 1'b1 :
                       started_r;

  // stop clears the counter; free run wraps to zero
  assign cnt_nxt = ~ch.counter_run ? 16'h0000 :               // RULE_13
                   ~adv            ? cnt_r :
                   clr_hit         ? 16'h0000 :
                   cnt_r + 16'h0001;                          // RULE_21

  // software clear or set wins, else toggle on enabled matches
  assign ff_nxt = ch.ff_clear ? 1'b0 :                        // RULE_09
                  ch.ff_set   ? 1'b1 :
                  ff_r ^ (m0 & ch.toggle_on_match_zero)       // RULE_03
                       ^ (m1 & ch.toggle_on_match_one);

  // =======================================================
  // prescaler, edge history and counter
  always_ff @(posedge clk_in) begin
    if (sys_rst_in) begin
      psc_r       <= 8'h00;
      pin_d_r     <= 1'b0;
      partner_d_r <= 1'b0;
      started_r   <= 1'b0;
      cnt_r       <= 16'h0000;
      ff_r        <= 1'b0;
      irq_r       <= 1'b0;
    end else begin
      psc_r       <= ch.prescaler_run ? psc_r + 8'h01 : 8'h00;
      pin_d_r     <= trigger_pin_in;
      partner_d_r <= partner_ff_in;
      started_r   <= started_nxt;
      cnt_r       <= cnt_nxt;
      ff_r        <= ff_nxt;
      irq_r       <= (m1 & ~ch.interrupt_mask[tpct_pkg::MASK_CMP1]) // RULE_07
                   | (m0 & ~ch.interrupt_mask[tpct_pkg::MASK_CMP0]) // RULE_12
                   | (ovf & ~ch.interrupt_mask[tpct_pkg::MASK_OVF]);
    end
  end

  // =======================================================
  // capture registers: soft capture, partner or pin edges
  always_ff @(posedge clk_in) begin
    if (sys_rst_in) begin
      cap0_r <= 16'h0000;
      cap1_r <= 16'h0000;
    end else begin
      if (ch.soft_capture) begin
        cap0_r <= cnt_r;                                      // RULE_19
      end else if (ch.capture_mode == tpct_pkg::CPM_PARTNER && par_rise) begin
        cap0_r <= cnt_r;                                      // RULE_14 RULE_15
      end else if (ch.capture_mode == tpct_pkg::CPM_PIN && pin_rise) begin
        cap0_r <= cnt_r;
      end
      if (ch.capture_mode == tpct_pkg::CPM_PARTNER && par_fall) begin
        cap1_r <= cnt_r;                                      // RULE_14 RULE_15
      end else if (ch.capture_mode == tpct_pkg::CPM_PIN && pin_fall) begin
        cap1_r <= cnt_r;
      end
    end
  end

  // state back to the register file
  assign ch.up_counter       = cnt_r;
  assign ch.capture_reg_zero = cap0_r;
  assign ch.capture_reg_one  = cap1_r;
  assign ch.timer_flip_flop  = ff_r;
  assign ch.match_interrupt  = irq_r;
  assign ch.started          = started_r;

endmodule : tpct_chan

// ### sim/tpct_properties.sv
`timescale 1ns/10ps
// =======================================================
// bus handshake and match pulse properties at the top ports
module tpct_properties (
  // clock and reset
  input wire logic        clk_in,
  input wire logic        sys_rst_in,
  // register bus
  input wire logic        axi_awvalid_in,
  input wire logic        axi_wvalid_in,
  input wire logic        axi_awready_out,
  input wire logic        axi_wready_out,
  input wire logic        axi_bvalid_out,
  input wire logic        axi_bready_in,
  input wire logic [1:0]  axi_bresp_out,
  input wire logic        axi_arvalid_in,
  input wire logic        axi_arready_out,
  input wire logic        axi_rvalid_out,
  input wire logic        axi_rready_in,
  input wire logic [31:0] axi_rdata_out,
  // timer pins
  input wire logic [1:0]  match_interrupt_out
);
  default clocking cb @(posedge clk_in); endclocking
  default disable iff (sys_rst_in);
  // write taken, then answered
  sequence wr_taken_s;
    axi_awready_out && axi_awvalid_in && axi_wvalid_in;
  endsequence
  sequence rd_taken_s;
    axi_arready_out && axi_arvalid_in;
  endsequence
  ready_pair_a: assert property (axi_awready_out == axi_wready_out)
    else $error("write readies differ");
  aw_pulse_a: assert property (axi_awready_out |=> !axi_awready_out)
    else $error("awready longer than one cycle");
  wr_answer_a: assert property (wr_taken_s |=> axi_bvalid_out)
    else $error("write response late");
  b_hold_a: assert property (axi_bvalid_out && !axi_bready_in
    |=> axi_bvalid_out && $stable(axi_bresp_out))
    else $error("write response dropped");
  rd_answer_a: assert property (rd_taken_s |=> axi_rvalid_out)
    else $error("read data late");
  r_hold_a: assert property (axi_rvalid_out && !axi_rready_in
    |=> axi_rvalid_out && $stable(axi_rdata_out))
    else $error("read data dropped");
  ar_wait_a: assert property (axi_arvalid_in && !axi_rvalid_out
    && !axi_arready_out |-> ##[1:2] axi_arready_out)
    else $error("read not taken");
  irq_pulse_a: assert property (match_interrupt_out[0] |=> !match_interrupt_out[0])
    else $error("match pulse too long");
endmodule : tpct_properties

// ### sim/tpct_pin_src.sv
`timescale 1ns/10ps
// =======================================================
// pin source: each enabled clock flips that channel's pin
module tpct_pin_src (
  // clock and reset
  input  wire logic       clk_in,
  input  wire logic       sys_rst_in,
  // toggle enables and pins
  input  wire logic [1:0] toggle_en_in,
  output logic      [1:0] pin_out
);
  // pins move just after a clock edge, idle low after reset
  always_ff @(posedge clk_in) begin
    if (sys_rst_in) begin
      pin_out <= 2'h0;
    end else begin
      pin_out <= pin_out ^ toggle_en_in;
    end
  end
endmodule : tpct_pin_src

// ### sim/tb_triggered_pulse_and_capture_timer.sv
`timescale 1ns/10ps
// =======================================================
// register traffic, one-shot, event count and capture
module tb_triggered_pulse_and_capture_timer;
  localparam logic [15:0] DLY = 16'h5;
  localparam logic [15:0] WID = 16'h4;
  logic        clk_in = 1'h0, sys_rst_in = 1'h1;
  logic        axi_awvalid_in = 1'h0, axi_wvalid_in = 1'h0;
  logic        axi_arvalid_in = 1'h0;
  logic        axi_bready_in = 1'h0, axi_rready_in = 1'h0;
  logic [7:0]  axi_awaddr_in = 8'h0, axi_araddr_in = 8'h0;
  logic [31:0] axi_wdata_in = 32'h0, axi_rdata_out, d, c0;
  logic        axi_awready_out, axi_wready_out, axi_bvalid_out;
  logic        axi_arready_out, axi_rvalid_out;
  logic [1:0]  axi_bresp_out, axi_rresp_out, r, pen = 2'h0;
  logic [1:0]  trigger_input_pin_in, pulse_output_pin_out, match_interrupt_out;
  int          errors = 0, compares = 0, n;
  tpct_top DUT (.clk_in, .sys_rst_in, .axi_awvalid_in, .axi_awready_out,
    .axi_awaddr_in, .axi_awprot_in(3'h0), .axi_wvalid_in, .axi_wready_out,
    .axi_wdata_in, .axi_wstrb_in(4'hf), .axi_bvalid_out, .axi_bready_in,
    .axi_bresp_out, .axi_arvalid_in, .axi_arready_out, .axi_araddr_in,
    .axi_arprot_in(3'h0), .axi_rvalid_out, .axi_rready_in, .axi_rdata_out,
    .axi_rresp_out, .trigger_input_pin_in, .pulse_output_pin_out,
    .match_interrupt_out);
  tpct_pin_src u_src (.clk_in, .sys_rst_in, .toggle_en_in(pen),
    .pin_out(trigger_input_pin_in));
  // 50 mhz clock
  always #10 clk_in = ~clk_in;
  task automatic chk(input string nm, input logic [31:0] s, e);
    compares++;
    if (s !== e) begin
      errors++;
      $display("[FAIL] %s expected %h seen %h", nm, e, s);
    end
  endtask : chk
  // bounded wait for a handshake flag
  task automatic wt(ref logic s);
    n = 0;
    do begin
      @(posedge clk_in);
      n++;
    end while (s !== 1'h1 && n < 100);
    if (s !== 1'h1) errors++;
  endtask : wt
  task automatic wr(input logic [7:0] a, input logic [31:0] v);
    axi_awaddr_in <= a;
    axi_wdata_in <= v;
    axi_awvalid_in <= 1'h1;
    axi_wvalid_in <= 1'h1;
    wt(axi_awready_out);
    axi_awvalid_in <= 1'h0;
    axi_wvalid_in <= 1'h0;
    wt(axi_bvalid_out);
    axi_bready_in <= 1'h1;
    wt(axi_bvalid_out);
    r = axi_bresp_out;
    axi_bready_in <= 1'h0;
  endtask : wr
  task automatic rc(input logic [7:0] a, input logic [31:0] e, input string nm);
    axi_araddr_in <= a;
    axi_arvalid_in <= 1'h1;
    wt(axi_arready_out);
    axi_arvalid_in <= 1'h0;
    wt(axi_rvalid_out);
    axi_rready_in <= 1'h1;
    wt(axi_rvalid_out);
    d = axi_rdata_out;
    r = axi_rresp_out;
    axi_rready_in <= 1'h0;
    chk(nm, d, e);
  endtask : rc
  // byte address of a channel register
  function automatic logic [7:0] ad(input logic c, input logic [3:0] i);
    return {1'h0, c, i, 2'h0};
  endfunction : ad
  task automatic conclude;
    $display("compares %0d errors %0d", compares, errors);
    if (errors == 0 && compares > 0) begin
      $display("== PASSED ==");
    end else begin
      $display("== FAILED ==");
    end
    $finish;
  endtask : conclude
  // watchdog against a hung handshake
  initial begin
    repeat (6000) @(posedge clk_in);
    errors++;
    conclude();
  end
  // =======================================================
  // test sequence
  initial begin
    repeat (20) @(posedge clk_in);
    sys_rst_in <= 1'h0;
    @(posedge clk_in);
    wr(8'h2c, 32'h1);
    chk("wr_unmapped", 32'(r), 32'(tpct_pkg::RESP_SLVERR));
    rc(8'h2c, 32'h0, "rd_unmapped");
    chk("rd_resp", 32'(r), 32'(tpct_pkg::RESP_SLVERR));
    rc(ad(1'h0, tpct_pkg::IDX_CMP1), 32'h0, "cmp1_reset");
    // one-shot after a trigger edge on channel 0
    wr(ad(1'h0, tpct_pkg::IDX_RUN), 32'h0);
    wr(ad(1'h0, tpct_pkg::IDX_CTRL), 32'h2);
    wr(ad(1'h0, tpct_pkg::IDX_CMP0), 32'(DLY));
    wr(ad(1'h0, tpct_pkg::IDX_CMP1), 32'(DLY + WID));
    wr(ad(1'h0, tpct_pkg::IDX_FFC), 32'he);
    wr(ad(1'h0, tpct_pkg::IDX_MODE), 32'h41);
    wr(ad(1'h0, tpct_pkg::IDX_MASK), 32'h5);
    wr(ad(1'h0, tpct_pkg::IDX_RUN), 32'h5);
    repeat (20) @(posedge clk_in);
    rc(ad(1'h0, tpct_pkg::IDX_COUNT), 32'h0, "armed_count");
    pen <= 2'h1;
    @(posedge clk_in);
    pen <= 2'h0;
    n = 0;
    while (pulse_output_pin_out[0] !== 1'h1 && n < 100) begin
      @(negedge clk_in);
      n++;
    end
    chk("pulse_rise", 32'(pulse_output_pin_out[0]), 32'h1);
    c0 = 32'h0;
    while (pulse_output_pin_out[0] === 1'h1 && c0 < 50) begin
      @(negedge clk_in);
      c0++;
    end
    chk("pulse_width", c0, 32'(2 * WID));
    chk("match_irq", 32'(match_interrupt_out[0]), 32'h1);
    @(posedge clk_in);
    wr(ad(1'h0, tpct_pkg::IDX_FFC), 32'h3);
    wr(ad(1'h0, tpct_pkg::IDX_FFC), 32'h1);
    chk("ff_set", 32'(pulse_output_pin_out[0]), 32'h1);
    wr(ad(1'h0, tpct_pkg::IDX_FFC), 32'h2);
    chk("ff_clear", 32'(pulse_output_pin_out[0]), 32'h0);
    wr(ad(1'h0, tpct_pkg::IDX_RUN), 32'h0);
    // channel 1 counts its pin, then a soft capture
    wr(ad(1'h1, tpct_pkg::IDX_MODE), 32'h40);
    wr(ad(1'h1, tpct_pkg::IDX_RUN), 32'h5);
    pen <= 2'h2;
    repeat (12) @(posedge clk_in);
    pen <= 2'h0;
    repeat (4) @(posedge clk_in);
    rc(ad(1'h1, tpct_pkg::IDX_COUNT), 32'h6, "event_count");
    wr(ad(1'h1, tpct_pkg::IDX_MODE), 32'h0);
    rc(ad(1'h1, tpct_pkg::IDX_CAP0), 32'h6, "soft_capture");
    // channel 1 captures on channel 0 flip-flop edges
    wr(ad(1'h1, tpct_pkg::IDX_RUN), 32'h0);
    wr(ad(1'h1, tpct_pkg::IDX_MODE), 32'h58);
    wr(ad(1'h1, tpct_pkg::IDX_RUN), 32'h5);
    pen <= 2'h2;
    wr(ad(1'h0, tpct_pkg::IDX_CTRL), 32'h0);
    wr(ad(1'h0, tpct_pkg::IDX_CMP0), 32'h3);
    wr(ad(1'h0, tpct_pkg::IDX_CMP1), 32'ha);
    wr(ad(1'h0, tpct_pkg::IDX_FFC), 32'he);
    wr(ad(1'h0, tpct_pkg::IDX_RUN), 32'h5);
    repeat (40) @(posedge clk_in);
    pen <= 2'h0;
    rc(ad(1'h1, tpct_pkg::IDX_CAP0), 32'hc, "cap0_read");
    c0 = d;
    rc(ad(1'h1, tpct_pkg::IDX_CAP1), 32'h13, "cap1_read");
    chk("capture_span", {16'h0, d[15:0] - c0[15:0]}, 32'h7);
    conclude();
  end
endmodule : tb_triggered_pulse_and_capture_timer
bind tpct_top tpct_properties u_props (.clk_in, .sys_rst_in,
  .axi_awvalid_in, .axi_wvalid_in, .axi_awready_out, .axi_wready_out,
  .axi_bvalid_out, .axi_bready_in, .axi_bresp_out, .axi_arvalid_in,
  .axi_arready_out, .axi_rvalid_out, .axi_rready_in, .axi_rdata_out,
  .match_interrupt_out);
